// ===== logic/flash_mode_defines.svh
// register offsets, field positions and reset values of the flash mode control block
`ifndef FLASH_MODE_DEFINES_SVH
`define FLASH_MODE_DEFINES_SVH
`define MODE_CTRL_OFFSET   8'h00
`define BLOCK_SEL_OFFSET   8'h04
`define MODE_CTRL_RESET    8'h00
`define BLOCK_SEL_RESET    10'h000
`define BIT_HW_ENABLE      7
`define BIT_SW_ENABLE      6
`define BIT_ERASE_SETUP    5
`define BIT_PROG_SETUP     4
`define BIT_ERASE_VERIFY   3
`define BIT_PROG_VERIFY    2
`define BIT_ERASE_RUN      1
`define BIT_PROG_RUN       0
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2
`endif

// ===== logic/flash_mode_pkg.sv
// types of the flash mode control block
`default_nettype none
package flash_mode_pkg;
	typedef enum logic [3:0] {
		ARRAY_READ   = 4'h1,
		ARRAY_SETUP  = 4'h2,
		ARRAY_VERIFY = 4'h4,
		ARRAY_RUN    = 4'h8
	} array_state_t;
endpackage
`default_nettype wire

// ===== logic/level_sync.sv
// two flip-flop synchroniser for an asynchronous pin level
`default_nettype none
module level_sync (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic asyncIn,
	output var  logic syncOut
);
	logic stage1_reg;
	logic stage1_next;
	logic stage2_next;

	always_comb begin
		stage1_next = asyncIn;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_reg <= 1'b0;
			syncOut    <= 1'b0;
		end else begin
			stage1_reg <= stage1_next;
			syncOut    <= stage2_next;
		end
	end
endmodule // level_sync
`default_nettype wire

// ===== logic/flash_mode_control.sv
// flash mode control register with AXI4-Lite slave
// How it works
// R1 - erase_setup bit 5 enters/leaves erase setup
// R2 - setup/verify bits need both enables set
// R3 - software sets erase_setup before erase_run
// R4 - program_setup bit 4 enters/leaves program setup
// R5 - software sets program_setup before program_run
// R6 - erase_verify bit 3 enters/leaves erase-verify
// R7 - program_verify bit 2 enters/leaves program-verify
// R8 - erase_run needs both enables and erase_setup
// R9 - software enable low blocks all other sets
// R10 - program_run needs software enable and program_setup
// R11 - reset clears all mode bits
`default_nettype none
`include "flash_mode_defines.svh"
module flash_mode_control
	import flash_mode_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        hwProgramEnablePin,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic [3:0]  arrayMode,
	output var  logic [9:0]  eraseBlockSelect
);
	logic         hwEnable;
	logic [6:0]   mode_reg;
	logic [6:0]   mode_next;
	logic [9:0]   blocks_next;
	logic         awHeld_reg;
	logic         awHeld_next;
	logic [7:0]   awAddr_reg;
	logic [7:0]   awAddr_next;
	logic         wHeld_reg;
	logic         wHeld_next;
	logic [31:0]  wData_reg;
	logic [31:0]  wData_next;
	logic [3:0]   wStrb_reg;
	logic [3:0]   wStrb_next;
	logic         awReady_next;
	logic         wReady_next;
	logic         bValid_next;
	logic [1:0]   bResp_next;
	logic         arReady_next;
	logic         rValid_next;
	logic [31:0]  rData_next;
	logic [1:0]   rResp_next;
	logic [3:0]   arrayMode_next;
	logic         doWrite;
	logic         swe;
	array_state_t arrayState;

	// pin level is asynchronous to ref_clk
	level_sync u_hw_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn (hwProgramEnablePin),
		.syncOut (hwEnable)
	);

	// mode_reg holds bits 6..0: sw enable, setup, verify and run bits
	assign swe     = mode_reg[`BIT_SW_ENABLE];
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	always_comb begin
		logic [7:0] wb;
		logic       nextSwe;
		wb          = wData_reg[7:0];
		mode_next   = mode_reg;
		blocks_next = eraseBlockSelect;
		nextSwe     = swe;
		if (doWrite && wStrb_reg[0] && awAddr_reg == `MODE_CTRL_OFFSET) begin
			// sw enable itself can only rise while the pin allows it
			nextSwe = wb[`BIT_SW_ENABLE] && (hwEnable || swe);
			mode_next[`BIT_SW_ENABLE] = nextSwe;
			mode_next[`BIT_ERASE_SETUP]  = wb[`BIT_ERASE_SETUP] && hwEnable && swe; // R1 R2 R9
			mode_next[`BIT_PROG_SETUP]   = wb[`BIT_PROG_SETUP] && hwEnable && swe; // R4 R2 R9
			mode_next[`BIT_ERASE_VERIFY] = wb[`BIT_ERASE_VERIFY] && hwEnable && swe; // R6 R2 R9
			mode_next[`BIT_PROG_VERIFY]  = wb[`BIT_PROG_VERIFY] && hwEnable && swe; // R7 R2 R9
			// run bits qualify on the setup bit already held, so setup must come first
			mode_next[`BIT_ERASE_RUN] = wb[`BIT_ERASE_RUN] && hwEnable && swe
				&& mode_reg[`BIT_ERASE_SETUP]; // R8 R3
			mode_next[`BIT_PROG_RUN] = wb[`BIT_PROG_RUN] && hwEnable && swe
				&& mode_reg[`BIT_PROG_SETUP]; // R10 R5
		end
		if (doWrite && wStrb_reg[0] && awAddr_reg == `BLOCK_SEL_OFFSET && swe) begin
			blocks_next[7:0] = wb;
		end
		if (doWrite && wStrb_reg[1] && awAddr_reg == `BLOCK_SEL_OFFSET && swe) begin
			blocks_next[9:8] = wData_reg[9:8];
		end
		// removing either enable drops every mode bit at once
		if (!hwEnable) begin
			mode_next = 7'h00;
		end
		if (!mode_next[`BIT_SW_ENABLE]) begin
			mode_next   = 7'h00; // R9
			blocks_next = `BLOCK_SEL_RESET; // R9
		end
	end

	always_comb begin
		if (mode_reg[`BIT_ERASE_RUN] || mode_reg[`BIT_PROG_RUN]) begin
			arrayState = ARRAY_RUN;
		end else if (mode_reg[`BIT_ERASE_VERIFY] || mode_reg[`BIT_PROG_VERIFY]) begin
			arrayState = ARRAY_VERIFY;
		end else if (mode_reg[`BIT_ERASE_SETUP] || mode_reg[`BIT_PROG_SETUP]) begin
			arrayState = ARRAY_SETUP;
		end else begin
			arrayState = ARRAY_READ;
		end
		arrayMode_next = 4'(arrayState);
	end

	// write channels are taken independently, one write at a time
	always_comb begin
		awHeld_next  = awHeld_reg;
		awAddr_next  = awAddr_reg;
		wHeld_next   = wHeld_reg;
		wData_next   = wData_reg;
		wStrb_next   = wStrb_reg;
		bValid_next  = s_axi_bvalid;
		bResp_next   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awAddr_next = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		if (doWrite) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bValid_next = 1'b1;
			bResp_next  = (awAddr_reg == `MODE_CTRL_OFFSET || awAddr_reg == `BLOCK_SEL_OFFSET)
				? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bValid_next = 1'b0;
		end
		awReady_next = !awHeld_next && !bValid_next;
		wReady_next  = !wHeld_next && !bValid_next;
	end

	always_comb begin
		arReady_next = s_axi_arready;
		rValid_next  = s_axi_rvalid;
		rData_next   = s_axi_rdata;
		rResp_next   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			arReady_next = 1'b0;
			rValid_next  = 1'b1;
			rResp_next   = `AXI_RESP_OKAY;
			rData_next   = 32'h0000_0000;
			case (s_axi_araddr[7:2])
				6'(`MODE_CTRL_OFFSET >> 2): begin
					rData_next[7:0] = {hwEnable, mode_reg};
				end
				6'(`BLOCK_SEL_OFFSET >> 2): begin
					rData_next[9:0] = eraseBlockSelect;
				end
				default: begin
					rResp_next = `AXI_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			rValid_next  = 1'b0;
			arReady_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg         <= 7'(`MODE_CTRL_RESET); // R11
			eraseBlockSelect <= `BLOCK_SEL_RESET;
			arrayMode        <= 4'h1;
			awHeld_reg       <= 1'b0;
			awAddr_reg       <= 8'h00;
			wHeld_reg        <= 1'b0;
			wData_reg        <= 32'h0000_0000;
			wStrb_reg        <= 4'h0;
			s_axi_awready    <= 1'b0;
			s_axi_wready     <= 1'b0;
			s_axi_bvalid     <= 1'b0;
			s_axi_bresp      <= 2'h0;
			s_axi_arready    <= 1'b0;
			s_axi_rvalid     <= 1'b0;
			s_axi_rdata      <= 32'h0000_0000;
			s_axi_rresp      <= 2'h0;
		end else begin
			mode_reg         <= mode_next;
			eraseBlockSelect <= blocks_next;
			arrayMode        <= arrayMode_next;
			awHeld_reg       <= awHeld_next;
			awAddr_reg       <= awAddr_next;
			wHeld_reg        <= wHeld_next;
			wData_reg        <= wData_next;
			wStrb_reg        <= wStrb_next;
			s_axi_awready    <= awReady_next;
			s_axi_wready     <= wReady_next;
			s_axi_bvalid     <= bValid_next;
			s_axi_bresp      <= bResp_next;
			s_axi_arready    <= (s_axi_arready || s_axi_rvalid) ? arReady_next : 1'b1;
			s_axi_rvalid     <= rValid_next;
			s_axi_rdata      <= rData_next;
			s_axi_rresp      <= rResp_next;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// enables are checked as they stood when the run bit was written
	a_erase_run_qual: assert property ( // R8
		$rose(mode_reg[`BIT_ERASE_RUN])
		|-> $past(mode_reg[`BIT_ERASE_SETUP]) && $past(swe) && $past(hwEnable))
		else $error("erase run set without setup");
	a_prog_run_qual: assert property ( // R10
		$rose(mode_reg[`BIT_PROG_RUN]) |-> $past(mode_reg[`BIT_PROG_SETUP]) && $past(swe))
		else $error("program run set without setup");
	a_setup_enables: assert property ( // R2
		$rose(mode_reg[`BIT_ERASE_SETUP]) || $rose(mode_reg[`BIT_PROG_SETUP])
		|-> $past(swe) && $past(hwEnable))
		else $error("setup bit set without enables");
	a_verify_enables: assert property ( // R2
		$rose(mode_reg[`BIT_ERASE_VERIFY]) || $rose(mode_reg[`BIT_PROG_VERIFY])
		|-> $past(swe) && $past(hwEnable))
		else $error("verify bit set without enables");
	a_swe_low_clear: assert property ( // R9
		!swe |-> mode_reg == 7'h00 && eraseBlockSelect == 10'h000)
		else $error("bits held while sw enable low");
	a_erase_setup_mode: assert property ( // R1
		mode_reg[5:0] == 6'h20 |=> arrayMode == 4'h2)
		else $error("erase setup not shown");
	a_prog_setup_mode: assert property ( // R4
		mode_reg[5:0] == 6'h10 |=> arrayMode == 4'h2)
		else $error("program setup not shown");
	a_verify_mode: assert property ( // R7
		mode_reg[5:0] == 6'h04 |=> arrayMode == 4'h4)
		else $error("program verify not shown");
	a_reset_state: assert property ( // R11
		$rose(reset_n) |-> mode_reg == 7'h00)
		else $error("mode bits not cleared by reset");
	a_bresp_order: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	c_erase_run: cover property (mode_reg[`BIT_ERASE_RUN]);
	c_prog_run: cover property (mode_reg[`BIT_PROG_RUN]);
	c_erase_verify: cover property (mode_reg[`BIT_ERASE_VERIFY]);
	c_refused_run: cover property (doWrite && wData_reg[1] && !mode_reg[`BIT_ERASE_SETUP]);
endmodule // flash_mode_control
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the flash mode control register block
`default_nettype none
`include "flash_mode_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_mode_pkg::*;
	logic        ref_clk, reset_n, hwProgramEnablePin;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, arrayMode;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [9:0]  eraseBlockSelect, blockVal;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  respQ[$], rrespQ[$];
	logic [31:0] rdataQ[$];
	int          fails, checksDone;

	flash_mode_control dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.hwProgramEnablePin(hwProgramEnablePin), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .arrayMode(arrayMode),
		.eraseBlockSelect(eraseBlockSelect));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// address and data are offered together; each is dropped only at its own handshake edge
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] resp = `AXI_RESP_OKAY);
		bit awDone, wDone;
		respQ.push_back(resp);
		awDone = 0;
		wDone = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge ref_clk);
			if (!awDone && s_axi_awready === 1'b1) begin
				awDone = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wDone && s_axi_wready === 1'b1) begin
				wDone = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// bready stays up between writes, so back-to-back calls never drive it twice at one edge
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] resp = `AXI_RESP_OKAY);
		rdataQ.push_back(exp);
		rrespQ.push_back(resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
	endtask

	// answers are matched against the oldest note left by the driver
	always @(posedge ref_clk) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			check("bresp", 32'(respQ.pop_front()), 32'(s_axi_bresp));
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			check("rdata", rdataQ.pop_front(), s_axi_rdata);
			check("rresp", 32'(rrespQ.pop_front()), 32'(s_axi_rresp));
		end
	end

	initial begin
		reset_n = 1'b0;
		hwProgramEnablePin = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(62));
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		check("arrayMode", 32'(ARRAY_READ), 32'(arrayMode));
		axiRead(`MODE_CTRL_OFFSET, 32'h00);
		axiWrite(`MODE_CTRL_OFFSET, 32'h7F);
		axiRead(`MODE_CTRL_OFFSET, 32'h00);
		hwProgramEnablePin <= 1'b1;
		// pin passes a two-stage synchroniser, so give it a spare edge
		repeat (3) @(posedge ref_clk);
		axiWrite(`MODE_CTRL_OFFSET, 32'h20);
		axiRead(`MODE_CTRL_OFFSET, 32'h80);
		axiWrite(`MODE_CTRL_OFFSET, 32'h40);
		axiRead(`MODE_CTRL_OFFSET, 32'hC0);
		for (int i = 2; i < 6; i++) begin
			axiWrite(`MODE_CTRL_OFFSET, 32'h40 | (32'h1 << i));
			axiRead(`MODE_CTRL_OFFSET, 32'hC0 | (32'h1 << i));
			check("arrayMode", 32'(i > 3 ? ARRAY_SETUP : ARRAY_VERIFY), 32'(arrayMode));
			axiWrite(`MODE_CTRL_OFFSET, 32'h40);
			axiRead(`MODE_CTRL_OFFSET, 32'hC0);
		end
		check("arrayMode", 32'(ARRAY_READ), 32'(arrayMode));
		axiWrite(`MODE_CTRL_OFFSET, 32'h42);
		axiRead(`MODE_CTRL_OFFSET, 32'hC0);
		axiWrite(`MODE_CTRL_OFFSET, 32'h60);
		axiWrite(`MODE_CTRL_OFFSET, 32'h62);
		axiRead(`MODE_CTRL_OFFSET, 32'hE2);
		check("arrayMode", 32'(ARRAY_RUN), 32'(arrayMode));
		axiWrite(`MODE_CTRL_OFFSET, 32'h60);
		// arrayMode follows the register one edge after bvalid rises
		@(posedge ref_clk);
		check("arrayMode", 32'(ARRAY_SETUP), 32'(arrayMode));
		axiWrite(`MODE_CTRL_OFFSET, 32'h41);
		axiRead(`MODE_CTRL_OFFSET, 32'hC0);
		axiWrite(`MODE_CTRL_OFFSET, 32'h50);
		axiWrite(`MODE_CTRL_OFFSET, 32'h51);
		axiRead(`MODE_CTRL_OFFSET, 32'hD1);
		check("arrayMode", 32'(ARRAY_RUN), 32'(arrayMode));
		axiWrite(`MODE_CTRL_OFFSET, 32'h50);
		axiRead(`MODE_CTRL_OFFSET, 32'hD0);
		// one block at a time, as erase software is expected to select
		blockVal = 10'h1 << ($urandom() % 10);
		axiWrite(`BLOCK_SEL_OFFSET, 32'(blockVal));
		axiRead(`BLOCK_SEL_OFFSET, 32'(blockVal));
		check("eraseBlockSelect", 32'(blockVal), 32'(eraseBlockSelect));
		axiWrite(`MODE_CTRL_OFFSET, 32'h00);
		axiRead(`BLOCK_SEL_OFFSET, 32'h0);
		axiWrite(`BLOCK_SEL_OFFSET, 32'(blockVal));
		axiRead(`BLOCK_SEL_OFFSET, 32'h0);
		axiWrite(8'h08, $urandom(), `AXI_RESP_SLVERR);
		axiRead(8'h08, 32'h0, `AXI_RESP_SLVERR);
		axiWrite(`MODE_CTRL_OFFSET, 32'h40);
		axiWrite(`MODE_CTRL_OFFSET, 32'h60);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("arrayMode", 32'(ARRAY_READ), 32'(arrayMode));
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		axiRead(`MODE_CTRL_OFFSET, 32'h80);
		wrap_up;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		$display("mismatch watchdog expected done seen hang");
		wrap_up;
	end
endmodule // tb
`default_nettype wire
